/* File: shared/flash_ctl_pkg.sv */
// Package with register map, field layout, command codes and state encoding for the flash sequencer
package flash_ctl_pkg;
  localparam logic [2:0] ADDR_PROTECTION = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_COMMAND = 3'h2;
  localparam logic [2:0] ADDR_DIVIDER = 3'h3;
  localparam logic [2:0] ADDR_TARGET = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
  localparam logic [2:0] ADDR_CONTROL = 3'h6;

  localparam int BIT_CBE = 7;
  localparam int BIT_CC = 6;
  localparam int BIT_PV = 5;
  localparam int BIT_AE = 4;
  localparam int BIT_BLANK = 2;
  localparam logic [7:0] STATUS_IMPL_MASK = 8'hF4;
  localparam logic [7:0] STATUS_W1C_MASK = 8'h30;
  localparam logic [7:0] STATUS_RESET = 8'hC0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
  localparam logic [7:0] CMD_BURST_PROG = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

  localparam int PAGE_BYTES = 512;
  localparam int PROT_SHIFT = 9;

  typedef struct packed {
    logic [6:0] protect_select;
    logic protection_disable;
  } protection_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } seq_state_e;
endpackage

/* File: src/flash_cmd_status_protect.sv */
// Flash command, status and protection register block with a simple sequencer
module flash_cmd_status_protect #(
  parameter int ADDR_W = 13
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] nonvolatile_protection_byte_i,
  input wire logic stop_mode_i,
  output logic array_start_o,
  output logic [7:0] array_cmd_o,
  output logic [ADDR_W-1:0] array_addr_o,
  output logic [7:0] array_data_o,
  input wire logic array_done_i,
  input wire logic array_blank_i,
  output logic irq_o
);
  localparam logic [ADDR_W-1:0] PAGE_MASK = ADDR_W'(flash_ctl_pkg::PAGE_BYTES - 1);
  // Boundary is compared at full select width so no high select bit is lost
  localparam int BOUND_W = $bits(flash_ctl_pkg::protection_s) - 1 + flash_ctl_pkg::PROT_SHIFT;

  flash_ctl_pkg::reg_req_s req;
  flash_ctl_pkg::protection_s prot_ff;
  flash_ctl_pkg::seq_state_e state_ff;
  logic [7:0] status_ff;
  logic [7:0] divider_ff;
  logic divider_set_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] cmd_ff;
  logic [ADDR_W-1:0] target_ff;
  logic [7:0] data_ff;
  logic loaded_ff;
  logic queued_ff;
  logic [7:0] q_cmd_ff;
  logic [ADDR_W-1:0] q_addr_ff;
  logic [7:0] q_data_ff;
  logic [7:0] rdata_ff;
  logic launch;
  logic cmd_legal;
  logic cmd_modifies;
  logic hits_protected;
  logic may_launch;
  logic good_launch;
  logic pv_event;
  logic ae_event;
  logic busy;
  logic [7:0] events;

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  function automatic logic is_legal(input logic [7:0] c);
    is_legal = (c == flash_ctl_pkg::CMD_BLANK) || (c == flash_ctl_pkg::CMD_BYTE_PROG) ||
               (c == flash_ctl_pkg::CMD_BURST_PROG) || (c == flash_ctl_pkg::CMD_PAGE_ERASE) ||
               (c == flash_ctl_pkg::CMD_MASS_ERASE);
  endfunction

  function automatic logic is_write_reg(input flash_ctl_pkg::reg_req_s r, input logic [2:0] a);
    is_write_reg = r.wr && (r.addr == a);
  endfunction

  // Protected block: addresses at or above the select boundary; mass erase touches it always
  always_comb begin
    logic [BOUND_W-1:0] boundary;
    boundary = '0;
    boundary = {prot_ff.protect_select, flash_ctl_pkg::PROT_SHIFT'(0)};
    if (prot_ff.protection_disable) begin
      hits_protected = 1'b0;
    end else if (cmd_ff == flash_ctl_pkg::CMD_MASS_ERASE) begin
      hits_protected = 1'b1;
    end else if (cmd_ff == flash_ctl_pkg::CMD_PAGE_ERASE) begin
      hits_protected = BOUND_W'(target_ff | PAGE_MASK) >= boundary;
    end else begin
      hits_protected = BOUND_W'(target_ff) >= boundary;
    end
  end

  assign busy = (state_ff == flash_ctl_pkg::ST_BUSY);
  assign launch = is_write_reg(req, flash_ctl_pkg::ADDR_STATUS) && req.wdata[flash_ctl_pkg::BIT_CBE] &&
                  status_ff[flash_ctl_pkg::BIT_CBE];
  assign cmd_legal = is_legal(cmd_ff);
  assign cmd_modifies = cmd_legal && (cmd_ff != flash_ctl_pkg::CMD_BLANK);
  // Queueing behind a running command is only for back-to-back burst programs
  assign may_launch = !busy || (cmd_ff == flash_ctl_pkg::CMD_BURST_PROG && array_cmd_o == flash_ctl_pkg::CMD_BURST_PROG
                      && !queued_ff);
  assign ae_event = (launch && (!cmd_legal || !may_launch || !loaded_ff || (cmd_modifies && !divider_set_ff))) ||
                    (busy && stop_mode_i);
  assign pv_event = launch && !ae_event && cmd_modifies && hits_protected;
  assign good_launch = launch && !ae_event && !pv_event;

  // Protection register: nonvolatile copy on the first cycle after reset, then only ever tightened
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      prot_ff <= flash_ctl_pkg::protection_s'(flash_ctl_pkg::ZERO_BYTE);
    end else if (!loaded_ff) begin
      prot_ff <= flash_ctl_pkg::protection_s'(nonvolatile_protection_byte_i);
    end else if (is_write_reg(req, flash_ctl_pkg::ADDR_PROTECTION) && !prot_ff.protection_disable &&
                 req.wdata[7:1] < prot_ff.protect_select) begin
      prot_ff.protect_select <= req.wdata[7:1];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  // Command, target and data staging registers, plus the divider and interrupt mask registers
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cmd_ff <= flash_ctl_pkg::ZERO_BYTE;
      target_ff <= '0;
      data_ff <= flash_ctl_pkg::ZERO_BYTE;
      divider_ff <= flash_ctl_pkg::ZERO_BYTE;
      divider_set_ff <= 1'b0;
      irq_mask_ff <= flash_ctl_pkg::ZERO_BYTE;
    end else begin
      if (is_write_reg(req, flash_ctl_pkg::ADDR_COMMAND)) begin
        cmd_ff <= req.wdata;
      end
      if (is_write_reg(req, flash_ctl_pkg::ADDR_TARGET)) begin
        target_ff <= {target_ff[ADDR_W-9:0], req.wdata};
      end
      if (is_write_reg(req, flash_ctl_pkg::ADDR_CONTROL)) begin
        data_ff <= req.wdata;
      end
      if (is_write_reg(req, flash_ctl_pkg::ADDR_DIVIDER) && !divider_set_ff) begin
        divider_ff <= req.wdata;
        divider_set_ff <= 1'b1;
      end
      if (is_write_reg(req, flash_ctl_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_ff <= req.wdata & flash_ctl_pkg::STATUS_IMPL_MASK;
      end
    end
  end

  // Sequencer: one active array command plus one buffered burst
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_ff <= flash_ctl_pkg::ST_IDLE;
      queued_ff <= 1'b0;
      q_cmd_ff <= flash_ctl_pkg::ZERO_BYTE;
      q_addr_ff <= '0;
      q_data_ff <= flash_ctl_pkg::ZERO_BYTE;
      array_start_o <= 1'b0;
      array_cmd_o <= flash_ctl_pkg::ZERO_BYTE;
      array_addr_o <= '0;
      array_data_o <= flash_ctl_pkg::ZERO_BYTE;
    end else begin
      array_start_o <= 1'b0;
      if (busy && stop_mode_i) begin
        state_ff <= flash_ctl_pkg::ST_IDLE;
        queued_ff <= 1'b0;
      end else if (good_launch && busy) begin
        queued_ff <= 1'b1;
        q_cmd_ff <= cmd_ff;
        q_addr_ff <= target_ff;
        q_data_ff <= data_ff;
      end else if (good_launch) begin
        state_ff <= flash_ctl_pkg::ST_BUSY;
        array_start_o <= 1'b1;
        array_cmd_o <= cmd_ff;
        array_addr_o <= target_ff;
        array_data_o <= data_ff;
      end else if (busy && array_done_i) begin
        if (queued_ff) begin
          queued_ff <= 1'b0;
          array_start_o <= 1'b1;
          array_cmd_o <= q_cmd_ff;
          array_addr_o <= q_addr_ff;
          array_data_o <= q_data_ff;
        end else begin
          state_ff <= flash_ctl_pkg::ST_DONE;
        end
      end else if (state_ff == flash_ctl_pkg::ST_DONE) begin
        state_ff <= flash_ctl_pkg::ST_IDLE;
      end
    end
  end

  // Status register; hardware set beats software clear
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      status_ff <= flash_ctl_pkg::STATUS_RESET;
    end else begin
      if (launch) begin
        status_ff[flash_ctl_pkg::BIT_CBE] <= 1'b0;
      end else if (busy && array_done_i && queued_ff) begin
        status_ff[flash_ctl_pkg::BIT_CBE] <= 1'b1;
      end else if (state_ff == flash_ctl_pkg::ST_IDLE || (busy && stop_mode_i)) begin
        status_ff[flash_ctl_pkg::BIT_CBE] <= 1'b1;
      end else if (busy && !queued_ff && cmd_ff == flash_ctl_pkg::CMD_BURST_PROG) begin
        status_ff[flash_ctl_pkg::BIT_CBE] <= 1'b1;
      end
      if (good_launch) begin
        status_ff[flash_ctl_pkg::BIT_CC] <= 1'b0;
      end else if (!busy && !queued_ff && status_ff[flash_ctl_pkg::BIT_CBE]) begin
        status_ff[flash_ctl_pkg::BIT_CC] <= 1'b1;
      end
      if (pv_event) begin
        status_ff[flash_ctl_pkg::BIT_PV] <= 1'b1;
      end else if (is_write_reg(req, flash_ctl_pkg::ADDR_STATUS) && req.wdata[flash_ctl_pkg::BIT_PV]) begin
        status_ff[flash_ctl_pkg::BIT_PV] <= 1'b0;
      end
      if (ae_event) begin
        status_ff[flash_ctl_pkg::BIT_AE] <= 1'b1;
      end else if (is_write_reg(req, flash_ctl_pkg::ADDR_STATUS) && req.wdata[flash_ctl_pkg::BIT_AE]) begin
        status_ff[flash_ctl_pkg::BIT_AE] <= 1'b0;
      end
      if (good_launch) begin
        status_ff[flash_ctl_pkg::BIT_BLANK] <= 1'b0;
      end else if (busy && array_done_i && array_cmd_o == flash_ctl_pkg::CMD_BLANK) begin
        status_ff[flash_ctl_pkg::BIT_BLANK] <= array_blank_i;
      end
      status_ff[3] <= 1'b0;
      status_ff[1:0] <= 2'b00;
    end
  end

  // Read port: data valid the cycle after the read strobe
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= flash_ctl_pkg::ZERO_BYTE;
    end else if (req.rd) begin
      case (req.addr)
        flash_ctl_pkg::ADDR_PROTECTION: rdata_ff <= prot_ff;
        flash_ctl_pkg::ADDR_STATUS: rdata_ff <= status_ff & flash_ctl_pkg::STATUS_IMPL_MASK;
        flash_ctl_pkg::ADDR_COMMAND: rdata_ff <= cmd_ff;
        flash_ctl_pkg::ADDR_DIVIDER: rdata_ff <= divider_ff;
        flash_ctl_pkg::ADDR_TARGET: rdata_ff <= target_ff[7:0];
        flash_ctl_pkg::ADDR_IRQ_MASK: rdata_ff <= irq_mask_ff;
        flash_ctl_pkg::ADDR_CONTROL: rdata_ff <= data_ff;
        default: rdata_ff <= flash_ctl_pkg::ZERO_BYTE;
      endcase
    end else begin
      rdata_ff <= flash_ctl_pkg::ZERO_BYTE;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign events = status_ff & flash_ctl_pkg::STATUS_IMPL_MASK;
  assign irq_o = |(events & irq_mask_ff);

  a_pv_sets: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pv_event |=> status_ff[flash_ctl_pkg::BIT_PV] && !array_start_o) else $error("violation flag not set");
  a_ae_sets: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ae_event |=> status_ff[flash_ctl_pkg::BIT_AE]) else $error("access error flag not set");
  a_ae_sticky: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    status_ff[flash_ctl_pkg::BIT_AE] && !(req.wr && req.addr == flash_ctl_pkg::ADDR_STATUS &&
    req.wdata[flash_ctl_pkg::BIT_AE]) |=> status_ff[flash_ctl_pkg::BIT_AE]) else $error("access error lost");
  a_illegal_code: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    launch && !is_legal(cmd_ff) |=> status_ff[flash_ctl_pkg::BIT_AE] && !array_start_o) else $error("illegal code taken");
  a_prot_grows: assert property (@(posedge sys_clk_i) disable iff (!resetn_i || !loaded_ff)
    $past(loaded_ff) |-> prot_ff.protect_select <= $past(prot_ff.protect_select)) else $error("protection loosened");
  a_prot_frozen: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    loaded_ff && prot_ff.protection_disable |=> $stable(prot_ff)) else $error("disabled protection changed");
  a_launch_clears: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    launch |=> !status_ff[flash_ctl_pkg::BIT_CBE]) else $error("buffer flag not cleared");
  a_cc_clears: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    good_launch |=> !status_ff[flash_ctl_pkg::BIT_CC] ##1 busy) else $error("complete flag not cleared");
  a_unimpl_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    req.rd && req.addr == flash_ctl_pkg::ADDR_STATUS |=> reg_rdata_o[3] == 1'b0 && reg_rdata_o[1:0] == 2'b00)
    else $error("reserved status bits set");
  a_nonburst_queue: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    queued_ff |-> q_cmd_ff == flash_ctl_pkg::CMD_BURST_PROG) else $error("non-burst queued");

  c_burst_queue: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) good_launch && busy);
  c_blank_done: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    busy && array_done_i && array_cmd_o == flash_ctl_pkg::CMD_BLANK && array_blank_i);
  c_violation: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) pv_event);
  c_stop_abort: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) busy && stop_mode_i);
endmodule

/* File: bench/flash_array_model.sv */
// Behavioural flash array answering start pulses after a chosen latency
module flash_array_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic array_start_i,
  input wire logic [7:0] array_cmd_i,
  input wire logic [7:0] latency_i,
  output logic array_done_o,
  output logic array_blank_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic erased_ff;
  logic busy_ff;
  logic [7:0] cnt_ff;
  always_ff @(posedge sys_clk_i) begin
    array_done_o <= 1'b0;
    if (!resetn_i) begin
      erased_ff <= 1'b0;
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      array_blank_o <= 1'b0;
    end else if (array_start_i) begin
      busy_ff <= 1'b1;
      cnt_ff <= latency_i;
      case (array_cmd_i)
        8'h20, 8'h25: erased_ff <= 1'b0;
        8'h41: erased_ff <= 1'b1;
        default: ;
      endcase
    end else if (busy_ff) begin
      if (cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        array_done_o <= 1'b1;
        array_blank_o <= erased_ff;
      end else begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end else begin
      // Result line toggles once its value is no longer valid
      array_blank_o <= ~array_blank_o;
    end
  end
endmodule

/* File: bench/flash_cmd_status_protect_bench.sv */
// Self-checking bench for the flash command, status and protection block
module flash_cmd_status_protect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, stop_mode_i = 0;
  logic [2:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0, nv_byte = 8'h10, lat = 8'h02, rdata, st_m, prot_m, mask_m, last_c, last_d;
  logic [7:0] reg_rdata_o, array_cmd_o, array_data_o;
  logic [12:0] array_addr_o, last_a;
  logic array_start_o, array_done_i, array_blank_i, irq_o, div_m, erased_m;
  int fail_count = 0, n_compared = 0, exp_starts = 0, n_starts = 0, cycles = 0, seed = 32'h0000_eee9;
  flash_cmd_status_protect #(.ADDR_W(13)) flash_cmd_status_protect_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .nonvolatile_protection_byte_i(nv_byte),
    .stop_mode_i(stop_mode_i), .array_start_o(array_start_o), .array_cmd_o(array_cmd_o),
    .array_addr_o(array_addr_o), .array_data_o(array_data_o), .array_done_i(array_done_i),
    .array_blank_i(array_blank_i), .irq_o(irq_o));
  flash_array_model flash_array_model_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .array_start_i(array_start_o), .array_cmd_i(array_cmd_o), .latency_i(lat),
    .array_done_o(array_done_i), .array_blank_o(array_blank_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (array_start_o === 1'b1) n_starts++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rdata = reg_rdata_o;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, e, rdata);
  endtask
  task automatic do_reset(input logic [7:0] nv);
    @(posedge sys_clk_i);
    nv_byte <= nv;
    resetn_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    st_m = 8'hC0;
    prot_m = nv;
    mask_m = 8'h00;
    div_m = 1'b0;
    erased_m = 1'b0;
    last_c = 8'h00;
    last_a = 13'h0000;
    last_d = 8'h00;
  endtask
  // Sends a full command sequence and predicts its outcome
  task automatic issue(input logic [7:0] c, input logic [12:0] a, input logic [7:0] d);
    logic prog;
    prog = (c != 8'h05);
    wr(flash_ctl_pkg::ADDR_TARGET, {3'b000, a[12:8]});
    wr(flash_ctl_pkg::ADDR_TARGET, a[7:0]);
    wr(flash_ctl_pkg::ADDR_CONTROL, d);
    wr(flash_ctl_pkg::ADDR_COMMAND, c);
    wr(flash_ctl_pkg::ADDR_STATUS, 8'h80);
    if (!(c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) || (prog && !div_m)) begin
      st_m = st_m | 8'h10;
    end else if (prog && !prot_m[0] && (c == 8'h41 || a >= {prot_m[7:1], 9'h000})) begin
      st_m = st_m | 8'h20;
    end else begin
      exp_starts++;
      last_c = c;
      last_a = a;
      last_d = d;
      st_m[2] = (c == 8'h05) && erased_m;
      if (c == 8'h41) erased_m = 1'b1;
      if (c[7:4] == 4'h2) erased_m = 1'b0;
    end
  endtask
  task automatic settle;
    rdata = 8'h00;
    for (int i = 0; i < 100 && !rdata[6]; i++) rd(flash_ctl_pkg::ADDR_STATUS);
    chk("status", st_m, rdata);
    chk("starts", exp_starts[12:0], n_starts[12:0]);
    chk("command", last_c, array_cmd_o);
    chk("address", last_a, array_addr_o);
    chk("data", last_d, array_data_o);
    chk("irq", |(st_m & mask_m), irq_o);
  endtask
  task automatic run(input logic [7:0] c, input logic [12:0] a, input logic [7:0] d);
    issue(c, a, d);
    settle();
  endtask
  task automatic clr(input logic [7:0] v);
    wr(flash_ctl_pkg::ADDR_STATUS, v);
    st_m = st_m & ~v;
    rdchk(flash_ctl_pkg::ADDR_STATUS, st_m, "flag clear");
  endtask
  initial begin
    do_reset(8'h10);
    rdchk(flash_ctl_pkg::ADDR_PROTECTION, 8'h10, "protection load");
    wr(flash_ctl_pkg::ADDR_STATUS, 8'h08);
    rdchk(flash_ctl_pkg::ADDR_STATUS, 8'hC0, "status unused bits");
    rdchk(3'h7, 8'h00, "unmapped");
    mask_m = 8'h30;
    wr(flash_ctl_pkg::ADDR_IRQ_MASK, mask_m);
    run(8'h20, 13'h0010, 8'h5A);
    wr(flash_ctl_pkg::ADDR_STATUS, 8'h00);
    rdchk(flash_ctl_pkg::ADDR_STATUS, st_m, "error kept");
    clr(8'h10);
    foreach (st_m[i]) begin
      run(8'h11 << (i % 4) ^ 8'h80, 13'h0000, 8'h00);
      clr(8'h10);
    end
    $display("test register access and errors done");
    wr(flash_ctl_pkg::ADDR_DIVIDER, 8'h13);
    div_m = 1'b1;
    wr(flash_ctl_pkg::ADDR_PROTECTION, 8'h20);
    rdchk(flash_ctl_pkg::ADDR_PROTECTION, prot_m, "protect grow only");
    wr(flash_ctl_pkg::ADDR_PROTECTION, 8'h0D);
    prot_m = 8'h0C;
    rdchk(flash_ctl_pkg::ADDR_PROTECTION, prot_m, "protect increase");
    run(8'h20, 13'h0C00, 8'h11);
    clr(8'h20);
    run(8'h20, 13'h0BFF, 8'h22);
    run(8'h41, 13'h0000, 8'h00);
    clr(8'h20);
    repeat (6) begin
      lat = 8'($random(seed) & 7);
      run(($random(seed) & 1) ? 8'h40 : 8'h20, 13'($random(seed) & 32'h7FF), 8'($random(seed)));
    end
    run(8'h05, 13'h0000, 8'h00);
    $display("test protection and commands done");
    do_reset(8'h11);
    wr(flash_ctl_pkg::ADDR_PROTECTION, 8'h02);
    rdchk(flash_ctl_pkg::ADDR_PROTECTION, 8'h11, "protect disabled");
    wr(flash_ctl_pkg::ADDR_DIVIDER, 8'h13);
    div_m = 1'b1;
    run(8'h41, 13'h0000, 8'h00);
    run(8'h05, 13'h0000, 8'h00);
    run(8'h20, 13'h1FFF, 8'h33);
    lat = 8'd30;
    issue(8'h25, 13'h0100, 8'h44);
    rdata = 8'h00;
    for (int i = 0; i < 100 && !rdata[7]; i++) rd(flash_ctl_pkg::ADDR_STATUS);
    issue(8'h25, 13'h0101, 8'h55);
    settle();
    issue(8'h40, 13'h0200, 8'h00);
    @(posedge sys_clk_i);
    stop_mode_i <= 1'b1;
    @(posedge sys_clk_i);
    stop_mode_i <= 1'b0;
    st_m = st_m | 8'h10;
    settle();
    while (flash_array_model_i.busy_ff) @(posedge sys_clk_i);
    $display("test burst and stop done");
    final_report();
  end
endmodule
